// ---- src/ucf_top.sv ----
// Serial clock generator, transmitter and receiver with APB registers.
// Assumes APB on i_clk; rxd and the clock pin are async.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
module ucf_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_rxd,
   output logic             o_txd,
   input  wire logic        i_xck,
   output logic             o_xck,
   output logic             o_xck_oe
);

   typedef struct packed {
      logic              rx_s1;
      logic              rx_s2;
      logic              xk_s1;
      logic              xk_s2;
      logic              xk_d;
      logic [11:0]       ctrl;
      logic [7:0]        div_lo;
      logic [3:0]        div_hi;
      logic [11:0]       bcnt;
      logic              ext_clock_pin;
      logic [13:0]       tx_sh;
      logic [3:0]        tx_left;
      logic [3:0]        tx_cnt;
      ucf_pkg::ucf_rx_st_t rx_st;
      logic [3:0]        rx_cnt;
      logic [3:0]        rx_idx;
      logic [8:0]        rx_sh;
      logic              rx_par;
      logic [8:0]        rx_data;
      logic              rx_valid;
      logic              rx_fe;
      logic              rx_pe;
      logic [31:0]       prdata;
   } ucf_state_t;

   // Line idle high at reset so no false start is seen
   localparam ucf_state_t S_RST = '{
      rx_s1:   1'b1,
      rx_s2:   1'b1,
      xk_s1:   1'b0,
      xk_s2:   1'b0,
      xk_d:    1'b0,
      ctrl:    ucf_pkg::CTRL_RST,
      div_lo:  ucf_pkg::DIVLO_RST,
      div_hi:  ucf_pkg::DIVHI_RST,
      bcnt:    12'h000,
      ext_clock_pin:     1'b0,
      tx_sh:   ucf_pkg::TXSH_IDLE,
      tx_left: 4'h0,
      tx_cnt:  4'h0,
      rx_st:   ucf_pkg::RX_IDLE,
      rx_cnt:  4'h0,
      rx_idx:  4'h0,
      rx_sh:   9'h000,
      rx_par:  1'b0,
      rx_data: 9'h000,
      rx_valid: 1'b0,
      rx_fe:   1'b0,
      rx_pe:   1'b0,
      prdata:  32'h0000_0000
   };

   ucf_state_t s_ff;
   ucf_state_t nxt_s;

   // Mode decode
   logic        sync_on;
   logic        master;
   logic        slave;
   logic        dbl;
   logic        pol;
   logic [3:0]  last;
   logic [3:0]  half;
   logic [11:0] divisor;
   logic        tick;
   logic        x_rise;
   logic        x_fall;
   logic        clk_run;
   logic        chg_edge;
   logic        smp_edge;
   logic [3:0]  nbits;
   logic        par_en;
   logic        par_odd;
   logic        stop2;
   logic        rxd;
   logic        addr_ok;
   logic        wr_en;
   logic        setup;

   // Frame image with start at bit 0; sync adds one idle lead bit
   function automatic logic [13:0] build_frame(
      input logic [8:0] d,
      input logic [3:0] nb,
      input logic       pen,
      input logic       podd,
      input logic       syn
   );
      logic [13:0] f;
      logic        p;
      logic [3:0]  pos;
      f   = ucf_pkg::TXSH_IDLE;
      p   = podd;
      pos = nb + 4'h1;
      f[0] = 1'b0;                          // see R19
      for (int i = 0; i < 9; i++) begin
         if (i < int'(nb)) begin
            f[i+1] = d[i];                  // see R17
            p      = p ^ d[i];              // see R21
         end
      end
      if (pen) begin
         f[pos] = p;                        // see R17
      end
      return syn ? {f[12:0], 1'b1} : f;
   endfunction : build_frame

   // Clock mode selection
   assign sync_on = s_ff.ctrl[ucf_pkg::CB_SYNC];                  // see R1
   assign master  = sync_on & s_ff.ctrl[ucf_pkg::CB_DIR];         // see R3
   assign slave   = sync_on & ~s_ff.ctrl[ucf_pkg::CB_DIR];        // see R3
   assign dbl     = ~sync_on & s_ff.ctrl[ucf_pkg::CB_DBL];        // see R2
   assign pol     = s_ff.ctrl[ucf_pkg::CB_POL];
   assign last    = dbl ? ucf_pkg::LAST_DBL : ucf_pkg::LAST_NORM; // see R10
   assign half    = dbl ? ucf_pkg::HALF_DBL : ucf_pkg::HALF_NORM;

   // Baud tick and divisor
   assign divisor = {s_ff.div_hi, s_ff.div_lo};                  // see R9
   assign tick    = (s_ff.bcnt == 12'h000);                      // see R6

   // Pin edges, taken from the second stage only
   assign x_rise  = s_ff.xk_s2 & ~s_ff.xk_d;                     // see R12
   assign x_fall  = ~s_ff.xk_s2 & s_ff.xk_d;                     // see R12
   // Master clock runs during a frame and ends its period
   assign clk_run = (s_ff.tx_left != 4'h0) | (s_ff.ext_clock_pin != pol);

   // Change and sample edges; pin ignored unless slave
   always_comb begin
      if (master) begin
         chg_edge = tick & clk_run & (s_ff.ext_clock_pin == pol);          // see R15
         smp_edge = tick & clk_run & (s_ff.ext_clock_pin != pol);          // see R14
      end else if (slave) begin
         chg_edge = pol ? x_fall : x_rise;                       // see R15
         smp_edge = pol ? x_rise : x_fall;                       // see R14
      end else begin
         chg_edge = 1'b0;                                        // see R4
         smp_edge = 1'b0;                                        // see R4
      end
   end

   // One format shared by both directions
   assign nbits   = (s_ff.ctrl[6:4] == ucf_pkg::CSZ_NINE) ? 4'h9 :
                    ucf_pkg::DATA_MIN + {2'b00, s_ff.ctrl[5:4]}; // see R22
   assign par_en  = s_ff.ctrl[ucf_pkg::CB_PAR+1];
   assign par_odd = s_ff.ctrl[ucf_pkg::CB_PAR];
   assign stop2   = s_ff.ctrl[ucf_pkg::CB_STOP2];
   assign rxd     = s_ff.rx_s2;

   // APB decode; zero wait states, stalled by clock enable
   assign addr_ok = (i_paddr == ucf_pkg::ADDR_CTRL)   |
                    (i_paddr == ucf_pkg::ADDR_DIVLO)  |
                    (i_paddr == ucf_pkg::ADDR_DIVHI)  |
                    (i_paddr == ucf_pkg::ADDR_TXDATA) |
                    (i_paddr == ucf_pkg::ADDR_RXDATA) |
                    (i_paddr == ucf_pkg::ADDR_STATUS);
   assign o_pready  = i_psel & i_penable & i_ce;
   assign o_pslverr = o_pready & ~addr_ok;
   assign wr_en     = o_pready & i_pwrite & addr_ok;
   assign setup     = i_psel & ~i_penable;

   // Next state of the whole block
   always_comb begin
      nxt_s = s_ff;
      // Two-stage synchronisers
      nxt_s.rx_s1 = i_rxd;
      nxt_s.rx_s2 = s_ff.rx_s1;
      nxt_s.xk_s1 = i_xck;
      nxt_s.xk_s2 = s_ff.xk_s1;
      nxt_s.xk_d  = s_ff.xk_s2;

      // Baud down-counter
      if (tick) begin
         nxt_s.bcnt = divisor;                                   // see R5
      end else begin
         nxt_s.bcnt = s_ff.bcnt - 12'h001;
      end

      // Master clock pin toggles per tick, so a bit spans two ticks
      if (master) begin
         if (tick & clk_run) begin
            nxt_s.ext_clock_pin = ~s_ff.ext_clock_pin;                               // see R23
         end
      end else begin
         nxt_s.ext_clock_pin = pol;                                        // see R23
      end

      // Transmit shifter, all ones when idle
      if (s_ff.tx_left != 4'h0) begin
         if (!sync_on) begin
            if (tick) begin
               if (s_ff.tx_cnt == last) begin                    // see R7
                  nxt_s.tx_cnt  = 4'h0;
                  nxt_s.tx_sh   = {1'b1, s_ff.tx_sh[13:1]};
                  nxt_s.tx_left = s_ff.tx_left - 4'h1;
               end else begin
                  nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
               end
            end
         end else if (chg_edge) begin
            nxt_s.tx_sh   = {1'b1, s_ff.tx_sh[13:1]};            // see R24
            nxt_s.tx_left = s_ff.tx_left - 4'h1;
         end
      end

      // Register reads captured in setup so read data is a flop
      if (setup) begin
         if (i_paddr == ucf_pkg::ADDR_CTRL) begin
            nxt_s.prdata = {20'h00000, s_ff.ctrl};
         end else if (i_paddr == ucf_pkg::ADDR_DIVLO) begin
            nxt_s.prdata = {24'h000000, s_ff.div_lo};
         end else if (i_paddr == ucf_pkg::ADDR_DIVHI) begin
            nxt_s.prdata = {28'h0000000, s_ff.div_hi};
         end else if (i_paddr == ucf_pkg::ADDR_RXDATA) begin
            nxt_s.prdata = {23'h000000, s_ff.rx_data};
         end else if (i_paddr == ucf_pkg::ADDR_STATUS) begin
            nxt_s.prdata = {27'h0000000,
                            s_ff.rx_st != ucf_pkg::RX_IDLE,
                            s_ff.rx_pe,
                            s_ff.rx_fe,
                            s_ff.rx_valid,
                            s_ff.tx_left != 4'h0};
         end else begin
            nxt_s.prdata = 32'h0000_0000;
         end
      end

      // Register writes
      if (wr_en) begin
         if (i_paddr == ucf_pkg::ADDR_CTRL) begin
            nxt_s.ctrl = i_pwdata[11:0];
         end else if (i_paddr == ucf_pkg::ADDR_DIVLO) begin
            nxt_s.div_lo = i_pwdata[7:0];
            nxt_s.bcnt   = {s_ff.div_hi, i_pwdata[7:0]};        // see R5
         end else if (i_paddr == ucf_pkg::ADDR_DIVHI) begin
            nxt_s.div_hi = i_pwdata[3:0];
         end else if (i_paddr == ucf_pkg::ADDR_TXDATA) begin
            // A write while a frame is out is dropped
            if (s_ff.ctrl[ucf_pkg::CB_TXEN] && s_ff.tx_left == 4'h0) begin
               nxt_s.tx_sh   = build_frame(i_pwdata[8:0], nbits,
                                           par_en, par_odd, sync_on); // see R16
               nxt_s.tx_left = nbits + 4'h2 + {3'b000, par_en} +
                               {3'b000, stop2} + {3'b000, sync_on};   // see R18
               nxt_s.tx_cnt  = 4'h0;
            end
         end
      end

      // Reading received data clears valid; a new frame below wins
      if (o_pready && !i_pwrite && i_paddr == ucf_pkg::ADDR_RXDATA) begin
         nxt_s.rx_valid = 1'b0;
      end

      // Receiver; async counts ticks per bit, sync uses sample edges
      if (!s_ff.ctrl[ucf_pkg::CB_RXEN]) begin
         nxt_s.rx_st = ucf_pkg::RX_IDLE;
      end else begin
         case (s_ff.rx_st)
            ucf_pkg::RX_IDLE: begin
               nxt_s.rx_cnt = 4'h0;
               nxt_s.rx_idx = 4'h0;
               nxt_s.rx_sh  = 9'h000;
               nxt_s.rx_par = par_odd;                           // see R21
               if (sync_on) begin
                  if (smp_edge && !rxd) begin
                     nxt_s.rx_st = ucf_pkg::RX_BITS;             // see R14
                  end
               end else if (tick && !rxd) begin
                  nxt_s.rx_st = ucf_pkg::RX_START;
               end
            end
            ucf_pkg::RX_START: begin
               // Mid-bit recheck rejects a false start
               if (tick) begin
                  if (s_ff.rx_cnt == half) begin                 // see R8
                     nxt_s.rx_cnt = 4'h0;
                     nxt_s.rx_st  = rxd ? ucf_pkg::RX_IDLE : ucf_pkg::RX_BITS;
                  end else begin
                     nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
                  end
               end
            end
            ucf_pkg::RX_BITS: begin
               if (!sync_on && tick) begin
                  nxt_s.rx_cnt = (s_ff.rx_cnt == last) ? 4'h0 :
                                 s_ff.rx_cnt + 4'h1;             // see R8
               end
               if (sync_on ? smp_edge : (tick && s_ff.rx_cnt == last)) begin
                  if (s_ff.rx_idx < nbits) begin
                     nxt_s.rx_sh[s_ff.rx_idx] = rxd;             // see R17
                     nxt_s.rx_par = s_ff.rx_par ^ rxd;           // see R21
                     nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
                     if (s_ff.rx_idx + 4'h1 == nbits && !par_en) begin
                        nxt_s.rx_par = 1'b0;
                        nxt_s.rx_st  = ucf_pkg::RX_STOP;
                     end
                  end else begin
                     // Parity slot: keep mismatch as the error
                     nxt_s.rx_par = s_ff.rx_par ^ rxd;           // see R21
                     nxt_s.rx_st  = ucf_pkg::RX_STOP;
                  end
               end
            end
            ucf_pkg::RX_STOP: begin
               if (!sync_on && tick) begin
                  nxt_s.rx_cnt = (s_ff.rx_cnt == last) ? 4'h0 :
                                 s_ff.rx_cnt + 4'h1;
               end
               // Only the first stop is looked at
               if (sync_on ? smp_edge : (tick && s_ff.rx_cnt == last)) begin
                  nxt_s.rx_data  = s_ff.rx_sh;
                  nxt_s.rx_fe    = ~rxd;                         // see R20
                  nxt_s.rx_pe    = s_ff.rx_par;
                  nxt_s.rx_valid = 1'b1;
                  nxt_s.rx_st    = ucf_pkg::RX_IDLE;             // see R20
               end
            end
            default: begin
               nxt_s.rx_st = ucf_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // State register, frozen while clock enable is low
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_ff <= S_RST;
      end else if (i_ce) begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from flops; pin enable is the AND of two control bits
   assign o_prdata = s_ff.prdata;
   assign o_txd    = s_ff.tx_sh[0];                              // see R19
   assign o_xck    = s_ff.ext_clock_pin;
   assign o_xck_oe = master;                                     // see R23

endmodule : ucf_top

// ---- src/ucf_pkg.sv ----
// Constants of the serial clock and frame block.
// Assumes APB on the same clock, word-aligned 8-bit addresses.
// Behaviour
// R1: Four clock modes; sync select picks async or sync.
// R2: Double speed only acts in async.
// R3: Sync: direction output means master, input means slave.
// R4: Clock pin clocks nothing when async.
// R5: Divisor counter reloads at zero and on low divisor write.
// R6: One tick per counter zero, clock over divisor plus one.
// R7: Transmit bit is 16, 8 or 2 ticks by mode.
// R8: Receiver uses ticks directly, 16, 8 or 2 states per bit.
// R9: Divisor is 12 bits from high and low registers.
// R10: Double speed receiver takes 8 samples per bit.
// R11: Software keeps double speed clear when sync.
// R12: Slave clock synchronised then edge detected, two cycles late.
// R13: Remote slave clock below a quarter of system clock.
// R14: Sync data sampled on the edge opposite its change.
// R15: Polarity clear: change rising, sample falling; set swaps.
// R16: All 30 formats: 5 to 9 data, parity, 1 or 2 stops.
// R17: Start, data LSB first, parity if on, then stops.
// R18: After a frame the next starts or the line idles high.
// R19: Start bit low, stop bits and idle high.
// R20: Receiver checks only the first stop bit.
// R21: Even parity is XOR of data, odd its inverse.
// R22: Both directions share one frame format.
// R23: Master drives clock pin from baud bit clock, idle at polarity.
// R24: Slave moves one bit per pin clock edge pair.
package ucf_pkg;
   // Register byte addresses
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_DIVLO  = 8'h04;
   localparam logic [7:0]  ADDR_DIVHI  = 8'h08;
   localparam logic [7:0]  ADDR_TXDATA = 8'h0C;
   localparam logic [7:0]  ADDR_RXDATA = 8'h10;
   localparam logic [7:0]  ADDR_STATUS = 8'h14;
   // Control field positions
   localparam int          CB_SYNC     = 0;
   localparam int          CB_DBL      = 1;
   localparam int          CB_DIR      = 2;
   localparam int          CB_POL      = 3;
   localparam int          CB_CSZ      = 4;
   localparam int          CB_PAR      = 7;
   localparam int          CB_STOP2    = 9;
   localparam int          CB_TXEN     = 10;
   localparam int          CB_RXEN     = 11;
   localparam logic [11:0] CTRL_RST    = 12'h030;
   localparam logic [7:0]  DIVLO_RST   = 8'h00;
   localparam logic [3:0]  DIVHI_RST   = 4'h0;
   // Ticks per bit minus one, and half point
   localparam logic [3:0]  LAST_NORM   = 4'hF;
   localparam logic [3:0]  LAST_DBL    = 4'h7;
   localparam logic [3:0]  HALF_NORM   = 4'h7;
   localparam logic [3:0]  HALF_DBL    = 4'h3;
   localparam logic [2:0]  CSZ_NINE    = 3'h7;
   localparam logic [3:0]  DATA_MIN    = 4'h5;
   localparam logic [13:0] TXSH_IDLE   = 14'h3FFF;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_BITS  = 2'b11,
      RX_STOP  = 2'b10
   } ucf_rx_st_t;
endpackage : ucf_pkg

// ---- testbench/ucf_properties.sv ----
// Bus and serial timing checks of ucf_top.
// Assumes only the bench writes the registers.
`timescale 1ns/100ps
module ucf_properties (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [31:0] o_prdata,
   input  wire logic        o_pready,
   input  wire logic        o_pslverr,
   input  wire logic        i_rxd,
   input  wire logic        o_txd,
   input  wire logic        i_xck,
   input  wire logic        o_xck,
   input  wire logic        o_xck_oe
);
   logic [11:0] ctrl_ff;
   logic [11:0] div_ff;
   logic [15:0] run_ff;
   logic [15:0] hcnt_ff;
   logic [3:0]  scnt_ff;
   logic        txd_ff;
   logic        xck_ff;
   logic        xin_ff;
   logic        dirty_ff;
   logic        wr;
   logic        pol;
   logic        slave;
   logic        xedge;
   logic [15:0] blen;
   assign wr    = i_psel & i_penable & i_ce & i_pwrite;
   assign pol   = ctrl_ff[ucf_pkg::CB_POL];
   assign slave = ctrl_ff[ucf_pkg::CB_SYNC] & ~ctrl_ff[ucf_pkg::CB_DIR];
   assign xedge = (i_xck != xin_ff) & (i_xck != pol);
   assign blen  = (16'(div_ff) + 16'h0001) << (ctrl_ff[ucf_pkg::CB_DBL] ? 3 : 4);
   // Settings shadow; a settings or data write spoils the measured run
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_ff  <= ucf_pkg::CTRL_RST;
         div_ff   <= 12'h000;
         run_ff   <= 16'h0000;
         hcnt_ff  <= 16'h0000;
         scnt_ff  <= 4'hF;
         txd_ff   <= 1'b1;
         xck_ff   <= 1'b0;
         xin_ff   <= 1'b0;
         dirty_ff <= 1'b1;
      end else begin
         if (wr && i_paddr == ucf_pkg::ADDR_CTRL) ctrl_ff <= i_pwdata[11:0];
         if (wr && i_paddr == ucf_pkg::ADDR_DIVLO) div_ff[7:0] <= i_pwdata[7:0];
         if (wr && i_paddr == ucf_pkg::ADDR_DIVHI) div_ff[11:8] <= i_pwdata[3:0];
         dirty_ff <= (wr && i_paddr <= ucf_pkg::ADDR_TXDATA) || (dirty_ff && o_txd == txd_ff);
         run_ff   <= (o_txd != txd_ff) ? 16'h0000 : run_ff + 16'h0001;
         hcnt_ff  <= (o_xck != xck_ff) ? 16'h0000 : hcnt_ff + 16'h0001;
         scnt_ff  <= xedge ? 4'h0 : ((scnt_ff == 4'hF) ? scnt_ff : scnt_ff + 4'h1);
         txd_ff   <= o_txd;
         xck_ff   <= o_xck;
         xin_ff   <= i_xck;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ready_zero_wait_a: assert property (i_psel && i_penable && i_ce |-> o_pready)
      else $error("no pready");
   unmapped_err_a: assert property (i_psel && i_penable && i_ce && i_paddr > ucf_pkg::ADDR_STATUS
      |-> o_pslverr) else $error("no pslverr");
   master_enable_a: assert property (o_xck_oe == (ctrl_ff[0] & ctrl_ff[2]))
      else $error("pin enable wrong");
   pin_idle_a: assert property (!o_xck_oe && $stable(ctrl_ff) |-> o_xck == pol)
      else $error("pin moves idle");
   bit_length_a: assert property (!ctrl_ff[0] && !dirty_ff && $rose(o_txd)
      |-> ((run_ff + 16'h0001) % blen) == 16'h0000) else $error("bit length wrong");
   half_period_a: assert property (o_xck_oe && $past(o_xck_oe) && $changed(o_xck)
      && o_xck == pol |-> hcnt_ff == 16'(div_ff)) else $error("half period wrong");
   change_edge_a: assert property (o_xck_oe && $changed(o_txd)
      |-> $changed(o_xck) && o_xck != pol) else $error("txd off change edge");
   slave_latency_a: assert property (slave && $changed(o_txd)
      |-> scnt_ff inside {[1:4]}) else $error("slave txd late");
endmodule : ucf_properties

bind ucf_top ucf_properties i_ucf_properties (.i_clk, .i_rst_n, .i_ce, .i_psel, .i_penable,
   .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rxd, .o_txd, .i_xck,
   .o_xck, .o_xck_oe);

// ---- testbench/ucf_remote.sv ----
// Remote transceiver: sends frames on rxd, clocking slave mode.
// Assumes the bench calls send from one process only.
`timescale 1ns/100ps
module ucf_remote (
   input  wire logic i_clk,
   output logic      o_rxd,
   output logic      o_xck
);
   // Line idles high, clock stands still between frames
   initial begin
      o_rxd = 1'b1;
      o_xck = 1'b0;
   end
   // Start low, data LSB first, parity, then high stops
   function automatic logic [12:0] frame_bits(input logic [8:0] d, input int nb,
                                              input logic [1:0] par, input logic two);
      logic [12:0] f;
      f = 13'h1FFF;
      f[0] = 1'b0;
      for (int k = 0; k < nb; k++) f[k + 1] = d[k];
      if (par[1]) f[nb + 1] = ^(d & ((9'h001 << nb) - 9'h001)) ^ par[0];
      return f;
   endfunction : frame_bits
   // Half period of 4 cycles keeps below a quarter rate
   task automatic send(input logic [12:0] f, input int len, input logic sync,
                       input logic pol, input int bitc);
      for (int k = 0; k < len; k++) begin
         @(posedge i_clk);
         o_rxd <= f[k];
         o_xck <= sync ? ~pol : pol;
         if (sync) begin
            repeat (4) @(posedge i_clk);
            o_xck <= pol;
            repeat (3) @(posedge i_clk);
         end else begin
            repeat (bitc - 1) @(posedge i_clk);
         end
      end
      @(posedge i_clk);
      o_rxd <= 1'b1;
   endtask : send
endmodule : ucf_remote

// ---- testbench/testbench.sv ----
// Bench of ucf_top: registers, async and sync frames.
// Assumes ucf_remote and the checker are compiled first.
`timescale 1ns/100ps
module testbench;
   logic        i_clk     = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        i_psel    = 1'b0;
   logic        i_penable = 1'b0;
   logic        i_pwrite  = 1'b0;
   logic [7:0]  i_paddr   = 8'h00;
   logic [31:0] i_pwdata  = 32'h0;
   logic [31:0] o_prdata;
   logic        o_pready, o_pslverr, i_rxd, o_txd, i_xck, o_xck, o_xck_oe, rem_xck;
   int          fails, n_compared, cyc;
   // Block drives the pin only as master
   assign i_xck = o_xck_oe ? o_xck : rem_xck;
   ucf_top i_ucf_top (.i_clk, .i_rst_n, .i_ce(1'b1), .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rxd, .o_txd, .i_xck, .o_xck, .o_xck_oe);
   ucf_remote i_ucf_remote (.i_clk, .o_rxd(i_rxd), .o_xck(rem_xck));
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   // Hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   task automatic complete_run;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Request held until pready at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wreg
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = '1,
                       input logic eerr = 1'b0);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, exp);
      chk(32'(e), 32'(eerr));
   endtask : rchk
   // Mode bits cleared first so the pin idles at the new polarity
   task automatic cfg(input logic [11:0] c, input logic [11:0] dv);
      wreg(ucf_pkg::ADDR_CTRL, {20'h0, c & 12'hFF8});
      wreg(ucf_pkg::ADDR_DIVHI, {28'h0, dv[11:8]});
      wreg(ucf_pkg::ADDR_DIVLO, {24'h0, dv[7:0]});
      wreg(ucf_pkg::ADDR_CTRL, {20'h0, c});
   endtask : cfg
   task automatic smp_edge(input logic pol);
      logic p;
      do begin
         p = o_xck;
         @(posedge i_clk);
      end while (!(o_xck !== p && o_xck === pol));
   endtask : smp_edge
   // Samples mid-bit when async, on the sample edge when sync
   task automatic get_frame(input logic sync, input logic pol, input int bitc, input int len,
                            output logic [12:0] f);
      f = 13'h1FFF;
      if (sync) begin
         do smp_edge(pol); while (o_txd !== 1'b0);
      end else begin
         while (o_txd !== 1'b0) @(posedge i_clk);
         repeat (bitc / 2) @(posedge i_clk);
      end
      for (int k = 0; k < len; k++) begin
         if (k > 0 && sync) smp_edge(pol);
         if (k > 0 && !sync) repeat (bitc) @(posedge i_clk);
         f[k] = o_txd;
      end
   endtask : get_frame
   int          nbs [4] = '{5, 7, 8, 9};
   logic [1:0]  pars[4] = '{2'b00, 2'b10, 2'b11, 2'b10};
   logic        twos[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   logic        dbls[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [11:0] divs[4] = '{12'h000, 12'h001, 12'h000, 12'h001};
   logic [8:0]  dats[4] = '{9'h015, 9'h05A, 9'h0C3, 9'h1A5};
   int          epos[3] = '{10, 11, 12};
   logic [31:0] ests[3] = '{32'h0000000A, 32'h00000006, 32'h00000002};
   initial begin
      int          bitc, len;
      logic [11:0] c;
      logic [12:0] f, exp;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rchk(ucf_pkg::ADDR_CTRL, 32'h030);
      rchk(ucf_pkg::ADDR_STATUS, 32'h0);
      rchk(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
      wreg(ucf_pkg::ADDR_DIVHI, 32'hFFFFFFFF);
      wreg(ucf_pkg::ADDR_DIVLO, 32'h000001FF);
      rchk(ucf_pkg::ADDR_DIVHI, 32'h00F);
      rchk(ucf_pkg::ADDR_DIVLO, 32'h0FF);
      $display("test registers done");
      for (int t = 0; t < 4; t++) begin
         c = {2'b11, twos[t], pars[t], (nbs[t] == 9) ? 3'h7 : 3'(nbs[t] - 5), 2'b00, dbls[t], 1'b0};
         bitc = (int'(divs[t]) + 1) * (dbls[t] ? 8 : 16);
         len = 2 + nbs[t] + int'(pars[t][1]) + int'(twos[t]);
         cfg(c, divs[t]);
         exp = i_ucf_remote.frame_bits(dats[t], nbs[t], pars[t], twos[t]);
         wreg(ucf_pkg::ADDR_TXDATA, {23'h0, dats[t]});
         get_frame(1'b0, 1'b0, bitc, len, f);
         chk(32'(f), 32'(exp));
         repeat (bitc) @(posedge i_clk);
         i_ucf_remote.send(exp, len, 1'b0, 1'b0, bitc);
         rchk(ucf_pkg::ADDR_STATUS, 32'h2);
         rchk(ucf_pkg::ADDR_RXDATA, {23'h0, dats[t]});
      end
      $display("test async frames done");
      for (int t = 0; t < 3; t++) begin
         i_ucf_remote.send(exp ^ (13'h0001 << epos[t]), len, 1'b0, 1'b0, bitc);
         rchk(ucf_pkg::ADDR_STATUS, ests[t], 32'h0000000E);
         rchk(ucf_pkg::ADDR_RXDATA, 32'h1A5);
      end
      // A low second stop starts one frame of all ones
      repeat (14 * bitc) @(posedge i_clk);
      rchk(ucf_pkg::ADDR_RXDATA, 32'h1FF);
      $display("test receive errors done");
      for (int p = 0; p < 2; p++) begin
         cfg({2'b01, 1'b0, 2'b00, 3'h3, 1'(p), 3'b101}, 12'h001);
         wreg(ucf_pkg::ADDR_TXDATA, 32'h03C);
         get_frame(1'b1, 1'(p), 0, 10, f);
         chk(32'(f), 32'(i_ucf_remote.frame_bits(9'h03C, 8, 2'b00, 1'b0)));
         repeat (20) @(posedge i_clk);
         chk(32'(o_xck), 32'(p));
      end
      $display("test sync master done");
      cfg({2'b11, 1'b0, 2'b00, 3'h3, 4'b0001}, 12'h000);
      wreg(ucf_pkg::ADDR_TXDATA, 32'h081);
      exp = i_ucf_remote.frame_bits(9'h096, 8, 2'b00, 1'b0);
      i_ucf_remote.send(exp, 10, 1'b1, 1'b0, 0);
      repeat (8) @(posedge i_clk);
      rchk(ucf_pkg::ADDR_STATUS, 32'h2, 32'h0000000E);
      rchk(ucf_pkg::ADDR_RXDATA, 32'h096);
      $display("test sync slave done");
      complete_run();
   end
endmodule : testbench
